// ---- hw/tpips_top.sv ----
// Purpose: transmit parallel input port with parity, self-test and error flag
// Assumes: pins and link clocks are asynchronous to mclk, sampled twice
// Notes:   character period is two reference edges (one when half rate)
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tpips_top #(
  parameter int             BIST_CHARS = tpips_pkg::BIST_LEN,
  parameter int             SYNC_CHARS = tpips_pkg::SYNC_LEN,
  parameter int             DEPTH      = tpips_pkg::PHASE_DEPTH,
  parameter logic [9:0]     VIOL_RAW   = 10'h3FF
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  // link clocks, sampled as pins
  input  wire logic                          reference_clock,
  input  wire logic                          tx_interface_clock,
  // host character inputs
  input  wire logic [7:0]                    tx_data,
  input  wire logic [1:0]                    tx_control_bits,
  input  wire logic                          tx_odd_parity_in,
  input  wire logic                          special_char_select,
  input  wire logic                          phase_align_reset_n,
  // error flag to host
  output logic                               tx_error_flag,
  // character to encoder or shifter
  output logic [9:0]                         char_out,
  output tpips_pkg::tpips_kind_type          char_kind,
  output logic                               char_raw,
  output logic                               char_valid,
  // register port
  input  wire logic [tpips_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [tpips_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [tpips_pkg::DATA_W-1:0]       reg_rdata,
  // interrupt
  output logic                               irq
);
  import tpips_pkg::*;

  function automatic logic is_low(input logic [1:0] lvl);
    return lvl == LVL_LOW;
  endfunction

  typedef struct packed {
    logic                 ref_s1;
    logic                 ref_s2;
    logic                 ref_d;
    logic                 txc_s1;
    logic                 txc_s2;
    logic                 txc_d;
    logic [PIN_W-1:0]     pin_s1;
    logic [PIN_W-1:0]     pin_s2;
    logic                 prst_s1;
    logic                 prst_s2;
    logic                 prst_low_d;
    logic [7:0]           cap_data;
    logic [1:0]           cap_ctl;
    logic                 cap_par;
    logic                 cap_sc;
    logic [CFG_W-1:0]     cfg;
    logic [EV_W-1:0]      status;
    logic [EV_W-1:0]      mask;
    tpips_bist_type       bist_st;
    logic [CNT_W-1:0]     bist_cnt;
    logic [CNT_W-1:0]     lfsr;
    logic [PULSE_W-1:0]   pulse_cnt;
    logic                 fault_d;
    logic                 err_flag;
    logic                 irq;
    logic [DATA_W-1:0]    rdata;
    logic [9:0]           char_out;
    tpips_kind_type       char_kind;
    logic                 char_raw;
    logic                 char_valid;
  } tpips_state_type;

  tpips_state_type      r;
  tpips_state_type      n;
  logic [1:0]           rst_sync;
  logic                 rst_n;
  logic                 ref_rise;
  logic                 ref_fall;
  logic                 txc_rise;
  logic                 half;
  logic                 tick;
  logic                 cap_stb;
  logic                 enc_on;
  logic                 bist_on;
  logic                 perr_now;
  logic                 phase_active;
  logic                 recenter;
  logic                 sync_done;
  logic                 pass_done;
  logic                 rx_mid;
  logic                 modes_ll;
  logic                 need_sync;
  tpips_kind_type       kind_now;
  logic                 fault;
  logic [LEVEL_W-1:0]   level;
  logic [EV_W-1:0]      ev;
  logic [EV_W-1:0]      clr;

  // reset release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // edge finding and configuration
  assign ref_rise     = r.ref_s2 & ~r.ref_d;
  assign ref_fall     = ~r.ref_s2 & r.ref_d;
  assign txc_rise     = r.txc_s2 & ~r.txc_d;
  assign half         = r.cfg[CFG_RATE];
  assign tick         = ref_rise | (half & ref_fall);
  assign cap_stb      = is_low(r.cfg[CFG_TXSEL+:2]) ? tick : txc_rise;
  assign enc_on       = !is_low(r.cfg[CFG_MODE1+:2]);
  assign bist_on      = r.cfg[CFG_BIST];
  assign rx_mid       = r.cfg[CFG_RXSEL+:2] == LVL_MID;
  assign modes_ll     = is_low(r.cfg[CFG_MODE0+:2]) && is_low(r.cfg[CFG_MODE1+:2]);
  assign need_sync    = is_low(r.cfg[CFG_RXSEL+:2]) && !modes_ll;
  assign phase_active = !is_low(r.cfg[CFG_TXSEL+:2]) || half;
  assign recenter     = ref_rise && !r.prst_s2 && r.prst_low_d;

  // odd parity over data, plus control when bypassed
  assign perr_now = !bist_on && !is_low(r.cfg[CFG_PARITY_CHECK_CONTROL+:2]) &&
                    (enc_on ? ~^{r.cap_data, r.cap_par}
                            : ~^{r.cap_ctl, r.cap_data, r.cap_par});

  // character classification
  always_comb begin
    case (r.cap_ctl)
      2'h0:    kind_now = r.cap_sc ? KIND_SPECIAL : KIND_DATA;
      2'h1:    kind_now = KIND_SPECIAL;
      2'h2:    kind_now = KIND_FILL;
      2'h3:    kind_now = KIND_SYNC;
      default: kind_now = KIND_DATA;
    endcase
  end

  assign pass_done = tick && bist_on &&
                     ((r.bist_st == BIST_RUN && !need_sync &&
                       r.bist_cnt == CNT_W'(BIST_CHARS - 1)) ||
                      (r.bist_st == BIST_SYNC &&
                       r.bist_cnt == CNT_W'(SYNC_CHARS - 1)));
  assign sync_done = tick &&
                     ((bist_on && r.bist_st == BIST_SYNC &&
                       r.bist_cnt == CNT_W'(SYNC_CHARS - 1)) ||
                      (!bist_on && enc_on && kind_now == KIND_SYNC && !perr_now));

  tpips_phase_mon #(
    .DEPTH (DEPTH)
  ) u_phase (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .active    (phase_active),
    .wr_tick   (cap_stb),
    .rd_tick   (tick),
    .recenter  (recenter),
    .sync_done (sync_done),
    .fault     (fault),
    .level     (level)
  );

  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    // pin sampling
    n.ref_s1 = reference_clock;
    n.ref_s2 = r.ref_s1;
    n.ref_d = r.ref_s2;
    n.txc_s1 = tx_interface_clock;
    n.txc_s2 = r.txc_s1;
    n.txc_d = r.txc_s2;
    n.pin_s1 = {tx_data, tx_control_bits, tx_odd_parity_in, special_char_select};
    n.pin_s2 = r.pin_s1;
    n.prst_s1 = phase_align_reset_n;
    n.prst_s2 = r.prst_s1;
    n.char_valid = 1'b0;
    n.fault_d = fault;
    if (ref_rise) begin
      n.prst_low_d = !r.prst_s2;
    end
    // input register
    if (cap_stb) begin
      n.cap_data = r.pin_s2[PIN_DATA+:8];
      n.cap_ctl = r.pin_s2[PIN_CTL+:2];
      n.cap_par = r.pin_s2[PIN_PAR];
      n.cap_sc = r.pin_s2[PIN_SC];
    end
    if (tick) begin
      n.char_valid = 1'b1;
      // self-test sequencer
      case (r.bist_st)
        BIST_IDLE: begin
          n.bist_cnt = '0;
          n.lfsr = LFSR_SEED;
          if (bist_on) begin
            n.bist_st = BIST_RUN;
          end
        end
        BIST_RUN: begin
          n.bist_cnt = r.bist_cnt + 1'b1;
          n.lfsr = {r.lfsr[CNT_W-2:0], r.lfsr[CNT_W-1] ^ r.lfsr[LFSR_TAP]};
          if (r.bist_cnt == CNT_W'(BIST_CHARS - 1)) begin
            n.bist_cnt = '0;
            if (need_sync) begin
              n.bist_st = BIST_SYNC;
            end
          end
        end
        BIST_SYNC: begin
          n.bist_cnt = r.bist_cnt + 1'b1;
          if (r.bist_cnt == CNT_W'(SYNC_CHARS - 1)) begin
            n.bist_cnt = '0;
            n.bist_st = BIST_RUN;
          end
        end
        default: begin
          n.bist_st = BIST_IDLE;
        end
      endcase
      if (!bist_on) begin
        n.bist_st = BIST_IDLE;
      end
      // completion pulse length
      if (pass_done) begin
        if (rx_mid || modes_ll) begin
          n.pulse_cnt = PULSE_W'(PULSE_SHORT);
        end else begin
          n.pulse_cnt = PULSE_W'(PULSE_LONG);
        end
      end else if (r.pulse_cnt != '0) begin
        n.pulse_cnt = r.pulse_cnt - 1'b1;
      end
      // character to encoder or shifter
      n.char_raw = !enc_on && !bist_on;
      if (bist_on) begin
        n.char_out = {2'h0, r.lfsr[7:0]};
        n.char_kind = (r.bist_st == BIST_SYNC) ? KIND_SYNC : KIND_DATA;
      end else if (perr_now) begin
        n.char_out = enc_on ? {2'h0, C07_CODE} : VIOL_RAW;
        n.char_kind = KIND_SPECIAL;
      end else if (enc_on) begin
        n.char_out = {2'h0, r.cap_data};
        n.char_kind = kind_now;
      end else begin
        n.char_out = {r.cap_ctl, r.cap_data};
        n.char_kind = KIND_DATA;
      end
      // error flag, one update per character edge
      n.err_flag = perr_now || (n.pulse_cnt != '0) || fault;
    end
    // events
    ev[EV_PARITY] = tick & perr_now;
    ev[EV_BIST] = pass_done;
    ev[EV_PHASE] = fault & ~r.fault_d;
    if (reg_wr && reg_addr == REG_STATUS) begin
      clr = reg_wdata[EV_W-1:0];
    end
    n.status = (r.status & ~clr) | ev;
    if (reg_wr && reg_addr == REG_MASK) begin
      n.mask = reg_wdata[EV_W-1:0];
    end
    if (reg_wr && reg_addr == REG_CONFIG) begin
      n.cfg = reg_wdata[CFG_W-1:0];
    end
    n.irq = |(n.status & n.mask);
    // read data, one cycle after the strobe
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: n.rdata[EV_W-1:0] = r.status;
        REG_MASK:   n.rdata[EV_W-1:0] = r.mask;
        REG_CONFIG: n.rdata[CFG_W-1:0] = r.cfg;
        REG_STATE: begin
          n.rdata[ST_ERR] = r.err_flag;
          n.rdata[ST_FAULT] = fault;
          n.rdata[ST_BIST+:2] = r.bist_st;
          n.rdata[ST_CNT+:CNT_W] = r.bist_cnt;
          n.rdata[ST_LEVEL+:LEVEL_W] = level;
        end
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tx_error_flag = r.err_flag;
  assign char_out = r.char_out;
  assign char_kind = r.char_kind;
  assign char_raw = r.char_raw;
  assign char_valid = r.char_valid;
  assign reg_rdata = r.rdata;
  assign irq = r.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_par_flag;
    tick && perr_now |=> r.err_flag && r.status[EV_PARITY];
  endproperty
  a_par_flag: assert property (p_par_flag) else $error("parity error not flagged");

  property p_subst;
    tick && perr_now && enc_on |=> r.char_out[7:0] == C07_CODE && r.char_kind == KIND_SPECIAL;
  endproperty
  a_subst: assert property (p_subst) else $error("bad character not replaced");

  property p_pulse_mid;
    pass_done && rx_mid |=> r.pulse_cnt == PULSE_W'(PULSE_SHORT) && r.err_flag;
  endproperty
  a_pulse_mid: assert property (p_pulse_mid) else $error("short pass pulse wrong");

  property p_pulse_long;
    pass_done && !rx_mid && !modes_ll |=> r.pulse_cnt == PULSE_W'(PULSE_LONG);
  endproperty
  a_pulse_long: assert property (p_pulse_long) else $error("long pass pulse wrong");

  property p_pulse_ll;
    pass_done && modes_ll |=> r.pulse_cnt == PULSE_W'(PULSE_SHORT) && r.bist_st == BIST_RUN;
  endproperty
  a_pulse_ll: assert property (p_pulse_ll) else $error("sync sent with modes low");

  property p_fault_flag;
    tick && fault |=> r.err_flag;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault not on error flag");

  property p_capture;
    cap_stb |=> r.cap_data == $past(r.pin_s2[PIN_DATA+:8]);
  endproperty
  a_capture: assert property (p_capture) else $error("character not captured");

  property p_flag_edges;
    !tick |=> $stable(r.err_flag);
  endproperty
  a_flag_edges: assert property (p_flag_edges) else $error("flag moved between edges");

endmodule // tpips_top

// ---- hw/tpips_pkg.sv ----
// Purpose: shared constants and types of the transmit input port block
// Assumes: three-level pins arrive as two-bit codes LOW, MID, HIGH
// Notes:   register offsets are byte addresses on a 32-bit data port
package tpips_pkg;

  // three-level select codes
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // register port
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATE  = 8'h0C;

  // status and mask bits
  localparam int EV_W      = 3;
  localparam int EV_PARITY = 0;
  localparam int EV_BIST   = 1;
  localparam int EV_PHASE  = 2;

  // config fields
  localparam int               CFG_W      = 12;
  localparam int               CFG_TXSEL  = 0;
  localparam int               CFG_RXSEL  = 2;
  localparam int               CFG_MODE0  = 4;
  localparam int               CFG_MODE1  = 6;
  localparam int               CFG_RATE   = 8;
  localparam int               CFG_PARITY_CHECK_CONTROL = 9;
  localparam int               CFG_BIST   = 11;
  localparam logic [CFG_W-1:0] CFG_RESET  = 12'h000;

  // state register fields
  localparam int ST_ERR   = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_BIST  = 2;
  localparam int ST_CNT   = 4;
  localparam int ST_LEVEL = 13;

  // synchronised pin bundle
  localparam int PIN_W    = 12;
  localparam int PIN_SC   = 0;
  localparam int PIN_PAR  = 1;
  localparam int PIN_CTL  = 2;
  localparam int PIN_DATA = 4;

  // self-test and character constants
  localparam int         CNT_W       = 9;
  localparam int         PULSE_W     = 5;
  localparam int         BIST_LEN    = 511;
  localparam int         SYNC_LEN    = 16;
  localparam int         PULSE_LONG  = 17;
  localparam int         PULSE_SHORT = 1;
  localparam int         LFSR_TAP    = 4;
  localparam logic [8:0] LFSR_SEED   = 9'h1FF;
  localparam logic [7:0] C07_CODE    = 8'hE0;
  localparam int         PHASE_DEPTH = 4;
  localparam int         LEVEL_W     = 3;

  typedef enum logic [1:0] {
    KIND_DATA    = 2'h0,
    KIND_SPECIAL = 2'h1,
    KIND_FILL    = 2'h2,
    KIND_SYNC    = 2'h3
  } tpips_kind_type;

  typedef enum logic [1:0] {
    BIST_IDLE = 2'h0,
    BIST_RUN  = 2'h1,
    BIST_SYNC = 2'h3
  } tpips_bist_type;

endpackage

// ---- hw/tpips_phase_mon.sv ----
// Purpose: phase-align buffer occupancy tracker with sticky fault
// Assumes: write and read ticks are one-cycle pulses on mclk
// Notes:   fault clears on sync done, recenter or while inactive, a new fault wins
`timescale 1ns/1ps
module tpips_phase_mon #(
  parameter int DEPTH = tpips_pkg::PHASE_DEPTH
) (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  // control
  input  wire logic                           active,
  input  wire logic                           wr_tick,
  input  wire logic                           rd_tick,
  input  wire logic                           recenter,
  input  wire logic                           sync_done,
  // state
  output logic                                fault,
  output logic [tpips_pkg::LEVEL_W-1:0]       level
);
  import tpips_pkg::*;

  localparam logic [LEVEL_W-1:0] CENTER = LEVEL_W'(DEPTH / 2);
  localparam logic [LEVEL_W-1:0] TOP    = LEVEL_W'(DEPTH - 1);

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic               fault;
  } tpips_pm_type;

  tpips_pm_type r;
  tpips_pm_type n;
  logic         ovf;
  logic         unf;
  logic         clr;

  always_comb begin
    n   = r;
    ovf = wr_tick & ~rd_tick & (r.level == TOP);
    unf = rd_tick & ~wr_tick & (r.level == '0);
    clr = sync_done | recenter | ~active;
    if (!active || recenter) begin
      n.level = CENTER;
    end else if (wr_tick && !rd_tick && !ovf) begin
      n.level = r.level + 1'b1;
    end else if (rd_tick && !wr_tick && !unf) begin
      n.level = r.level - 1'b1;
    end
    n.fault = (r.fault & ~clr) | (active & (ovf | unf));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign fault = r.fault;
  assign level = r.level;

  property p_fault_hold;
    @(posedge mclk) disable iff (!rst_n)
    r.fault && active && !sync_done && !recenter |=> r.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("phase fault dropped early");

  property p_fault_set;
    @(posedge mclk) disable iff (!rst_n)
    active && !recenter && wr_tick && !rd_tick && r.level == TOP |=> r.fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("overflow not flagged");

endmodule // tpips_phase_mon

// ---- verif/tpips_host_model.sv ----
// Purpose: host side of the transmit port, makes link clocks and pins
// Assumes: reference and interface clocks 80 ns period, 16 mclk cycles, interface 40 ns, 8 mclk cycles, when fast
// Notes:   pins change at phase F, clear of both rising edges
`timescale 1ns/1ps
module tpips_host_model (
  // clock
  input  wire logic        mclk,
  // bench controls
  input  wire logic        fast,
  input  wire logic        enc_on,
  input  wire logic        bad_par,
  input  wire logic [7:0]  data,
  input  wire logic [1:0]  ctl,
  input  wire logic        sc,
  // pins
  output logic             reference_clock,
  output logic             tx_interface_clock,
  output logic [7:0]       tx_data,
  output logic [1:0]       tx_control_bits,
  output logic             tx_odd_parity_in,
  output logic             special_char_select
);
  logic [3:0] phase_reg = 4'h0;
  logic       if_edge;

  initial begin
    reference_clock = 1'b0;
    tx_interface_clock = 1'b0;
    tx_data = 8'h00;
    tx_control_bits = 2'h0;
    tx_odd_parity_in = 1'b1;
    special_char_select = 1'b0;
  end

  // fast interface clock overruns the phase buffer
  assign if_edge = fast ? (phase_reg[1:0] == 2'h1) : (phase_reg[2:0] == 3'h3);

  always @(posedge mclk) begin
    phase_reg <= phase_reg + 4'h1;
    if (phase_reg[2:0] == 3'h7) begin
      reference_clock <= ~reference_clock;
    end
    if (if_edge) begin
      tx_interface_clock <= ~tx_interface_clock;
    end
    // character pins held steady across the rising edges
    if (phase_reg == 4'hF) begin
      tx_data <= data;
      tx_control_bits <= ctl;
      special_char_select <= sc;
      tx_odd_parity_in <= (enc_on ? ~^data : ~^{ctl, data}) ^ bad_par;
    end
  end
endmodule // tpips_host_model

// ---- verif/tpips_top_bench.sv ----
// Purpose: self-checking bench of the transmit input port
// Assumes: short self-test counts, 200 MHz mclk
// Notes:   each scenario is one task
`timescale 1ns/1ps
module tpips_top_bench;
  import tpips_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        phase_align_reset_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        fast = 1'b0;
  logic        enc_on = 1'b1;
  logic        bad_par = 1'b0;
  logic [7:0]  data = 8'h00;
  logic [1:0]  ctl = 2'h0;
  logic        sc = 1'b0;
  logic        ref_clk, if_clk, par_pin, sc_pin, tx_error_flag, char_raw, char_valid, irq;
  logic [7:0]  data_pin;
  logic [1:0]  ctl_pin;
  logic [9:0]  char_out;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  tpips_kind_type char_kind;
  int          bad_count = 0;
  int          n_checks = 0;
  int          n;
  logic [9:0]  ch;

  always #2.5 mclk = ~mclk;

  tpips_host_model HOST (.mclk(mclk), .fast(fast), .enc_on(enc_on), .bad_par(bad_par),
    .data(data), .ctl(ctl), .sc(sc), .reference_clock(ref_clk), .tx_interface_clock(if_clk),
    .tx_data(data_pin), .tx_control_bits(ctl_pin), .tx_odd_parity_in(par_pin),
    .special_char_select(sc_pin));

  tpips_top #(.BIST_CHARS(15), .SYNC_CHARS(4)) DUT (.mclk(mclk), .resetn(resetn),
    .reference_clock(ref_clk), .tx_interface_clock(if_clk), .tx_data(data_pin),
    .tx_control_bits(ctl_pin), .tx_odd_parity_in(par_pin), .special_char_select(sc_pin),
    .phase_align_reset_n(phase_align_reset_n), .tx_error_flag(tx_error_flag),
    .char_out(char_out), .char_kind(char_kind), .char_raw(char_raw),
    .char_valid(char_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    check(32'hDEAD, 32'h0);
    complete_run();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask

  function automatic logic [31:0] cfgv(logic [1:0] tx, logic [1:0] rx, logic [1:0] m0,
    logic [1:0] m1, logic rate, logic [1:0] par, logic bist);
    return {20'h0, bist, par, rate, m1, m0, rx, tx};
  endfunction

  task automatic ticks(input int k);
    int c;
    int got;
    c = 0;
    got = 0;
    while (got < k && c < 40 * k) begin
      @(posedge mclk);
      c++;
      if (char_valid === 1'b1) got++;
    end
    if (got < k) timeout();
  endtask

  // length of the next error flag run in characters, and the character then
  task automatic flag_run(output int len, output logic [9:0] chr);
    int c;
    c = 0;
    while (tx_error_flag !== 1'b1 && c < 3000) begin
      @(posedge mclk);
      c++;
    end
    if (c >= 3000) timeout();
    chr = char_out;
    c = 0;
    while (tx_error_flag === 1'b1 && c < 3000) begin
      @(posedge mclk);
      c++;
    end
    len = (c + 8) / 16;
  endtask

  task automatic bad_char();
    bad_par <= 1'b1;
    ticks(1);
    bad_par <= 1'b0;
  endtask

  task automatic recenter();
    phase_align_reset_n <= 1'b0;
    repeat (40) @(posedge mclk);
    phase_align_reset_n <= 1'b1;
  endtask

  task automatic t_regs();
    rd(REG_STATUS, rv);
    check(rv, 32'h0);
    rd(REG_CONFIG, rv);
    check(rv, 32'h0);
    wr(8'h10, 32'h5);
    rd(8'h10, rv);
    check(rv, 32'h0);
    wr(REG_MASK, 32'h7);
    rd(REG_MASK, rv);
    check(rv, 32'h7);
    $display("test regs done");
  endtask

  task automatic t_classify();
    tpips_kind_type kinds [5] = '{KIND_DATA, KIND_SPECIAL, KIND_FILL, KIND_SYNC, KIND_SPECIAL};
    wr(REG_CONFIG, cfgv(LVL_LOW, LVL_MID, LVL_LOW, LVL_HIGH, 1'b0, LVL_HIGH, 1'b0));
    for (int i = 0; i < 5; i++) begin
      data <= 8'h5A + 8'(i);
      ctl <= 2'(i);
      sc <= (i == 4);
      ticks(4);
      check(32'(char_out), {24'h0, 8'h5A + 8'(i)});
      check(32'(char_kind), 32'(kinds[i]));
      check(32'(char_raw), 32'h0);
      check(32'(tx_error_flag), 32'h0);
    end
    ctl <= 2'h0;
    sc <= 1'b0;
    ticks(3);
    bad_char();
    flag_run(n, ch);
    check(32'(n), 32'h1);
    check(32'(ch), {22'h0, 2'h0, C07_CODE});
    check(32'(irq), 32'h1);
    rd(REG_STATUS, rv);
    check(rv, 32'h1);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, rv);
    check(rv, 32'h0);
    check(32'(irq), 32'h0);
    $display("test classify and parity done");
  endtask

  task automatic t_raw();
    enc_on <= 1'b0;
    ctl <= 2'h2;
    data <= 8'h33;
    wr(REG_CONFIG, cfgv(LVL_LOW, LVL_MID, LVL_LOW, LVL_LOW, 1'b0, LVL_HIGH, 1'b0));
    ticks(4);
    check(32'(char_out), 32'h233);
    check(32'(char_raw), 32'h1);
    bad_char();
    flag_run(n, ch);
    check(32'(n), 32'h1);
    check(32'(ch), 32'h3FF);
    wr(REG_STATUS, 32'h7);
    $display("test raw done");
  endtask

  task automatic t_bist(input logic [1:0] rx, input logic [1:0] m, input int exp);
    wr(REG_CONFIG, cfgv(LVL_LOW, rx, m, m, 1'b0, LVL_LOW, 1'b1));
    flag_run(n, ch);
    check(32'(n), 32'(exp));
    rd(REG_STATUS, rv);
    check(rv, 32'h2);
    wr(REG_STATUS, 32'h2);
    wr(REG_CONFIG, 32'h0);
    ticks(3);
    $display("test self-test rx %0d done", rx);
  endtask

  task automatic t_phase();
    enc_on <= 1'b1;
    ctl <= 2'h0;
    wr(REG_CONFIG, cfgv(LVL_HIGH, LVL_MID, LVL_LOW, LVL_HIGH, 1'b0, LVL_LOW, 1'b0));
    recenter();
    ticks(4);
    check(32'(tx_error_flag), 32'h0);
    fast <= 1'b1;
    ticks(8);
    fast <= 1'b0;
    ticks(6);
    check(32'(tx_error_flag), 32'h1);
    check(32'(irq), 32'h1);
    rd(REG_STATE, rv);
    check(32'(rv[ST_FAULT:ST_ERR]), 32'h3);
    rd(REG_STATUS, rv);
    check(rv, 32'h4);
    recenter();
    ticks(3);
    check(32'(tx_error_flag), 32'h0);
    fast <= 1'b1;
    ticks(8);
    check(32'(tx_error_flag), 32'h1);
    fast <= 1'b0;
    ctl <= 2'h3;
    ticks(6);
    check(32'(tx_error_flag), 32'h0);
    ctl <= 2'h0;
    wr(REG_STATUS, 32'h4);
    @(posedge mclk);
    check(32'(irq), 32'h0);
    $display("test phase done");
  endtask

  task automatic t_half();
    int c;
    c = 0;
    wr(REG_CONFIG, cfgv(LVL_LOW, LVL_MID, LVL_LOW, LVL_HIGH, 1'b1, LVL_LOW, 1'b0));
    recenter();
    ticks(2);
    repeat (160) begin
      @(posedge mclk);
      if (char_valid === 1'b1) c++;
    end
    check(32'(c), 32'd20);
    $display("test half rate done");
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_classify();
    t_raw();
    t_bist(LVL_MID, LVL_HIGH, 1);
    t_bist(LVL_LOW, LVL_HIGH, 17);
    t_bist(LVL_HIGH, LVL_LOW, 1);
    t_phase();
    t_half();
    complete_run();
  end
endmodule // tpips_top_bench
